// ==== rtl/rx_cfg_defs.svh ====
// Constants for the receiver mode and configuration control ends.
`ifndef RX_CFG_DEFS_SVH
`define RX_CFG_DEFS_SVH
// ==========================================================================
// Serial target address and register offsets.
`define TGT_ADDR 7'h76
`define OFS_VND_LO 4'h0
`define OFS_VND_HI 4'h1
`define OFS_DEV_LO 4'h2
`define OFS_DEV_HI 4'h3
`define OFS_DEV_REV 4'h4
`define OFS_EQ 4'h9
`define OFS_OUT 4'ha
`define OFS_PLL 4'hb
// ==========================================================================
// Field positions.
`define POS_STAG 5
`define POS_OCKINV 4
`define POS_CLOCK_DE_DRIVE_STRENGTH 3
`define POS_ST 2
`define POS_ZONE 3
// ==========================================================================
// Reset values.
`define RST_EQ 4'hd
`define RST_STAG 1'b1
`define RST_OCKINV 1'b0
`define RST_CLOCK_DE_DRIVE_STRENGTH 1'b0
`define RST_ST 1'b1
`define RST_LBW 2'h0
// ==========================================================================
// Bandwidth codes and their loop bandwidth in MHz.
`define LBW_4MHZ 2'h0
`define LBW_3MHZ 2'h1
`define LBW_6MHZ 2'h2
`define LBW_5MHZ 2'h3
// ==========================================================================
// Timing: serial clock may not exceed 400 kHz at a 250 MHz system clock.
`define CLK_MHZ 250
`define SCL_MAX_KHZ 400
`define SCL_QTR_CYC ((`CLK_MHZ * 1000 + 4 * `SCL_MAX_KHZ - 1) / (4 * `SCL_MAX_KHZ))
// ==========================================================================
// Host command port offsets and control bit positions.
`define H_CTRL 2'h0
`define H_CMD 2'h1
`define H_DATA 2'h2
`define H_STAT 2'h3
`define HC_MODE 0
`define HC_PDN 1
`define HC_ODN 2
`define HC_SEL 3
`define HC_ST 4
`define HC_OCKINV 5
`define HC_RST 6'h1d
`define HCMD_READ 4
`endif

// ==== rtl/rx_cfg_pkg.sv ====
// Types shared by the device end and the host end.
package rx_cfg_pkg;
  // ========================================================================
  // Pixel bus width of the video outputs.
  localparam int PIX_W = 24;

  // Pin sample group, used for each synchroniser stage.
  typedef struct packed {
    logic mode;
    logic pdn;
    logic odn;
    logic sel;
    logic scl;
    logic sda;
  } pins_t;

  // Device serial target states.
  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_ADDR_ACK, D_REG, D_REG_ACK, D_WDATA, D_WACK, D_RDATA, D_RACK
  } dev_state_t;

  // Complete device state.
  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t last;
    dev_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [3:0] ptr;
    logic rw;
    logic ack_ok;
    logic sda_low;
    logic [3:0] eq;
    logic stag_n;
    logic ockinv;
    logic clock_de_drive_strength;
    logic st_drv;
    logic [1:0] pll_bandwidth_sel;
    logic [PIX_W-1:0] pix;
    logic de;
    logic hs;
    logic vs;
    logic vid_en;
  } dev_t;

  // Kinds of step in a host transaction.
  typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} kind_t;

  // Complete host state.
  typedef struct packed {
    logic [5:0] ctrl;
    logic busy;
    logic nack;
    logic rd;
    logic [3:0] regaddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rdq;
    logic [2:0] step;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [15:0] div;
    logic scl_low;
    logic sda_low;
    logic s1;
    logic s2;
  } host_t;
endpackage

// ==== rtl/rx_cfg_if.sv ====
// Pin-level carrier joining the host controller and the receiver.
interface rx_cfg_if;
  // ========================================================================
  // Straps and control pins, all driven by the host.
  logic mode_strap;
  logic power_down_n;
  logic output_disable_n;
  logic serial_sel;
  // Open-drain drivers; an enable low pulls the line to the driven value.
  logic host_scl_o;
  logic host_scl_oen;
  logic host_sda_o;
  logic host_sda_oen;
  logic dev_sda_o;
  logic dev_sda_oen;
  // Resolved line levels; a released line is held high by its pull-up.
  logic scl;
  logic sda;

  assign scl = host_scl_oen | host_scl_o;
  assign sda = (host_sda_oen | host_sda_o) & (dev_sda_oen | dev_sda_o);

  // Receiver side.
  modport dev (
    input mode_strap, power_down_n, output_disable_n, serial_sel, scl, sda,
    output dev_sda_o, dev_sda_oen
  );

  // Host controller side.
  modport host (
    output mode_strap, power_down_n, output_disable_n, serial_sel,
    output host_scl_o, host_scl_oen, host_sda_o, host_sda_oen,
    input sda
  );
endinterface

// ==== rtl/rx_cfg_dev.sv ====
// Receiver end: strap mode selection, serial register target and output control.
// Function
// - Strap high: legacy pin mode; low: programmable.
// - Host ties mode and serial select low; here mode follows a host control bit that resets high.
// - Registers reached as I2C target, max 400kHz.
// - Programmable mode repurposes three strap pins.
// - Host resets serial logic once at power-up.
// - Power-down release edge resets serial logic.
// - External logic pulses power-down for reset.
// - Output disable tristates video, enables pull-downs.
// - Mode strap gates serial bus responsiveness.
// - Host enables one instance's serial port only.
// - Power-down disables outputs, logic, register access.
// - Power-down or mode toggle restores defaults.
// - Staggered mode: DE aligns with even pixel; here the stagger bit only drives an output, and DE is not realigned.
// - Equalizer code maps monotonically to compensation.
// - Bandwidth field selects recovery PLL bandwidth.
// - Fixed seven-bit target address for all.
// - Bandwidth codes: 4, 3, 6, 5 MHz.
// - Equalizer defaults to code 1101.
//
// The register offsets and the address-and-strobe port were decided locally.
`include "rx_cfg_defs.svh"

module rx_cfg_dev
  import rx_cfg_pkg::*;
#(
  parameter logic [6:0] TGT_ADDR = `TGT_ADDR,
  parameter logic [15:0] VENDOR_ID = 16'h0000, // Arbitrary value.
  parameter logic [15:0] DEVICE_ID = 16'h0000, // Arbitrary value.
  parameter logic [7:0] DEVICE_REV = 8'h00 // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rx_cfg_if.dev pins,
  input wire logic [PIX_W-1:0] pixel_i,
  input wire logic de_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic zone_i,
  output logic [PIX_W-1:0] pixel_o,
  output logic de_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic video_oen_o,
  output logic pulldown_en_o,
  output logic prog_mode_o,
  output logic [3:0] equalizer_setting_o,
  output logic [3:0] eq_strength_o,
  output logic [1:0] pll_bandwidth_sel_o,
  output logic [2:0] pll_bw_mhz_o,
  output logic staggered_output_n_o,
  output logic data_drive_strength_o,
  output logic clock_de_drive_strength_o,
  output logic out_clock_invert_o
);

  // ========================================================================
  // Elaboration check: reserved serial addresses cannot be served.
  if (TGT_ADDR[6:3] == 4'h0 || TGT_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("Target address falls in a reserved range.");
  end

  dev_t q; // Registered state.
  dev_t d; // Next state.
  logic prog; // Programmable mode selected.
  logic live; // Serial target may respond.
  logic scl_rise; // Serial clock rising edge.
  logic scl_fall; // Serial clock falling edge.
  logic start_c; // Start condition seen.
  logic stop_c; // Stop condition seen.
  logic cfg_clr; // Configuration registers return to defaults.
  logic [7:0] rd_byte; // Read value at the current pointer.

  // ========================================================================
  // Register read map; reserved locations read as zero.
  function automatic logic [7:0] reg_read(input logic [3:0] a, input dev_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `OFS_VND_LO: v = VENDOR_ID[7:0];
      `OFS_VND_HI: v = VENDOR_ID[15:8];
      `OFS_DEV_LO: v = DEVICE_ID[7:0];
      `OFS_DEV_HI: v = DEVICE_ID[15:8];
      `OFS_DEV_REV: v = DEVICE_REV;
      `OFS_EQ: v = {4'h0, s.eq};
      `OFS_OUT: begin
        v[`POS_STAG] = s.stag_n;
        v[`POS_OCKINV] = s.ockinv;
        v[`POS_CLOCK_DE_DRIVE_STRENGTH] = s.clock_de_drive_strength;
        v[`POS_ST] = s.st_drv;
      end
      `OFS_PLL: begin
        v[`POS_ZONE] = zone_i;
        v[1:0] = s.pll_bandwidth_sel;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ========================================================================
  // Next-state logic for synchronisers, serial target, registers and video.
  always_comb begin
    d = q;
    // Every pin comes from the host's domain, so it passes two flops first.
    d.s1 = '{mode: pins.mode_strap, pdn: pins.power_down_n, odn: pins.output_disable_n,
             sel: pins.serial_sel, scl: pins.scl, sda: pins.sda};
    d.s2 = q.s1;
    d.last = q.s2;
    prog = ~q.s2.mode;
    live = prog & q.s2.pdn;
    scl_rise = q.s2.scl & ~q.last.scl;
    scl_fall = ~q.s2.scl & q.last.scl;
    start_c = q.s2.scl & q.last.scl & q.last.sda & ~q.s2.sda;
    stop_c = q.s2.scl & q.last.scl & ~q.last.sda & q.s2.sda;
    rd_byte = reg_read(q.ptr, q);
    // Defaults while powered down, in legacy mode, on the release edge of
    // power-down and on any change of the mode strap.
    cfg_clr = ~q.s2.pdn | q.s2.mode | (q.s2.pdn & ~q.last.pdn)
              | (q.s2.mode ^ q.last.mode);
    if (!live || (q.s2.pdn && !q.last.pdn)) begin
      // A disabled or freshly reset target lets go of the bus entirely.
      d.st = D_IDLE;
      d.sda_low = 1'b0;
    end else if (start_c) begin
      // A repeated start also lands here and restarts addressing.
      d.st = D_ADDR;
      d.cnt = 4'h0;
      d.sda_low = 1'b0;
    end else if (stop_c) begin
      d.st = D_IDLE;
      d.sda_low = 1'b0;
    end else if (scl_rise) begin
      unique case (q.st)
        D_ADDR, D_REG, D_WDATA: begin
          d.sh = {q.sh[6:0], q.s2.sda};
          d.cnt = q.cnt + 4'h1;
        end
        D_RDATA: begin
          // Shift out the bit just presented; the next one is in sh[7].
          d.sh = {q.sh[6:0], 1'b0};
          d.cnt = q.cnt + 4'h1;
        end
        D_RACK: d.ack_ok = ~q.s2.sda;
        default: d.ack_ok = q.ack_ok;
      endcase
    end else if (scl_fall) begin
      // Data on the line only changes while the clock is low.
      unique case (q.st)
        D_ADDR: if (q.cnt == 4'h8) begin
          if (q.sh[7:1] == TGT_ADDR) begin
            d.st = D_ADDR_ACK;
            d.rw = q.sh[0];
            d.sda_low = 1'b1;
          end else begin
            d.st = D_IDLE;
          end
        end
        D_REG: if (q.cnt == 4'h8) begin
          d.ptr = q.sh[3:0];
          d.st = D_REG_ACK;
          d.sda_low = 1'b1;
        end
        D_WDATA: if (q.cnt == 4'h8) begin
          d.ptr = q.ptr + 4'h1;
          d.st = D_WACK;
          d.sda_low = 1'b1;
        end
        D_ADDR_ACK: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st = D_RDATA;
            d.sh = rd_byte;
            d.sda_low = ~rd_byte[7];
          end else begin
            d.st = D_REG;
            d.sda_low = 1'b0;
          end
        end
        D_REG_ACK, D_WACK: begin
          d.st = D_WDATA;
          d.cnt = 4'h0;
          d.sda_low = 1'b0;
        end
        D_RDATA: if (q.cnt == 4'h8) begin
          d.st = D_RACK;
          d.ptr = q.ptr + 4'h1;
          d.sda_low = 1'b0;
        end else begin
          d.sda_low = ~q.sh[7];
        end
        D_RACK: begin
          // A not-acknowledge ends the read; the host then sends a stop.
          d.st = q.ack_ok ? D_RDATA : D_IDLE;
          d.cnt = 4'h0;
          d.sh = rd_byte;
          d.sda_low = q.ack_ok & ~rd_byte[7];
        end
        default: d.st = D_IDLE;
      endcase
    end
    // Register writes land on the last data bit's falling clock edge.
    if (cfg_clr) begin
      d.eq = `RST_EQ;
      d.stag_n = `RST_STAG;
      d.ockinv = `RST_OCKINV;
      d.clock_de_drive_strength = `RST_CLOCK_DE_DRIVE_STRENGTH;
      d.st_drv = `RST_ST;
      d.pll_bandwidth_sel = `RST_LBW;
    end else if (live && scl_fall && q.st == D_WDATA && q.cnt == 4'h8) begin
      unique case (q.ptr)
        `OFS_EQ: d.eq = q.sh[3:0];
        `OFS_OUT: begin
          d.stag_n = q.sh[`POS_STAG];
          d.ockinv = q.sh[`POS_OCKINV];
          d.clock_de_drive_strength = q.sh[`POS_CLOCK_DE_DRIVE_STRENGTH];
          d.st_drv = q.sh[`POS_ST];
        end
        `OFS_PLL: d.pll_bandwidth_sel = q.sh[1:0];
        default: d.pll_bandwidth_sel = q.pll_bandwidth_sel;
      endcase
    end
    // Video stage; powered-down logic passes nothing through.
    d.vid_en = q.s2.pdn & q.s2.odn;
    d.pix = q.s2.pdn ? pixel_i : '0;
    // DE is registered in the same stage as its own pixel; pixels are not grouped into pairs.
    d.de = q.s2.pdn & de_i;
    d.hs = q.s2.pdn & hsync_i;
    d.vs = q.s2.pdn & vsync_i;
  end

  // ========================================================================
  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= D_IDLE;
      q.eq <= `RST_EQ;
      q.stag_n <= `RST_STAG;
      q.st_drv <= `RST_ST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs. In legacy mode the three shared pins act as plain straps.
  assign pins.dev_sda_o = 1'b0;
  assign pins.dev_sda_oen = ~q.sda_low;
  assign pixel_o = q.pix;
  assign de_o = q.de;
  assign hsync_o = q.hs;
  assign vsync_o = q.vs;
  assign video_oen_o = ~q.vid_en;
  assign pulldown_en_o = ~q.vid_en;
  assign prog_mode_o = ~q.s2.mode;
  assign equalizer_setting_o = q.eq;
  // Larger compensation for smaller codes, in strict order.
  assign eq_strength_o = 4'hf - q.eq;
  assign pll_bandwidth_sel_o = q.pll_bandwidth_sel;
  always_comb begin
    unique case (q.pll_bandwidth_sel)
      `LBW_4MHZ: pll_bw_mhz_o = 3'h4;
      `LBW_3MHZ: pll_bw_mhz_o = 3'h3;
      `LBW_6MHZ: pll_bw_mhz_o = 3'h6;
      `LBW_5MHZ: pll_bw_mhz_o = 3'h5;
    endcase
  end
  assign staggered_output_n_o = q.s2.mode ? q.s2.sel : q.stag_n;
  assign data_drive_strength_o = q.s2.mode ? q.s2.sda : q.st_drv;
  assign out_clock_invert_o = q.s2.mode ? q.s2.scl : q.ockinv;
  assign clock_de_drive_strength_o = q.clock_de_drive_strength;
endmodule

// ==== rtl/rx_cfg_host.sv ====
// Host end: drives the straps and power-down pins and masters the serial bus.
`include "rx_cfg_defs.svh"

module rx_cfg_host
  import rx_cfg_pkg::*;
#(
  parameter int QTR_CYC = `SCL_QTR_CYC // Clock cycles per quarter of a serial bit.
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic busy_o,
  rx_cfg_if.host pins
);

  // ========================================================================
  // Elaboration check: the target needs several cycles per quarter bit.
  if (QTR_CYC < 8 || QTR_CYC > 65535) begin : g_bad_qtr
    $error("QTR_CYC must lie between 8 and 65535.");
  end
  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

  host_t q; // Registered state.
  host_t d; // Next state.
  kind_t kind; // Kind of the current step.
  logic [7:0] tx_byte; // Byte sent in the current step.
  logic [2:0] stop_step; // Index of the closing stop.

  // ========================================================================
  // Step table: a write is start, address, pointer, data, stop; a read
  // sends no data but a repeated start, a read address and one byte that it answers with a NACK.
  always_comb begin
    stop_step = q.rd ? 3'd6 : 3'd4;
    tx_byte = 8'h00;
    kind = K_TX;
    unique case (q.step)
      3'd0: kind = K_START;
      3'd1: tx_byte = {`TGT_ADDR, 1'b0};
      3'd2: tx_byte = {4'h0, q.regaddr};
      3'd3: begin
        kind = q.rd ? K_START : K_TX;
        tx_byte = q.wdata;
      end
      3'd4: begin
        kind = q.rd ? K_TX : K_STOP;
        tx_byte = {`TGT_ADDR, 1'b1};
      end
      3'd5: kind = K_RX;
      default: kind = K_STOP;
    endcase
  end

  // ========================================================================
  // Command port and bus sequencer.
  always_comb begin
    d = q;
    d.s1 = pins.sda;
    d.s2 = q.s1;
    if (rd_i) begin
      unique case (addr_i)
        `H_CTRL: d.rdq = {2'b00, q.ctrl};
        `H_CMD: d.rdq = {3'b000, q.rd, q.regaddr};
        `H_DATA: d.rdq = q.rdata;
        `H_STAT: d.rdq = {6'h00, q.nack, q.busy};
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        `H_CTRL: d.ctrl = wdata_i[5:0];
        `H_DATA: d.wdata = wdata_i;
        `H_STAT: d.nack = q.nack;
        `H_CMD: if (!q.busy && !q.ctrl[`HC_MODE]) begin
          // Commands are refused while busy or with the target in legacy mode.
          d.busy = 1'b1;
          d.nack = 1'b0;
          d.rd = wdata_i[`HCMD_READ];
          d.regaddr = wdata_i[3:0];
          d.step = 3'd0;
          d.qtr = 2'd0;
          d.bitn = 4'h0;
          d.div = 16'h0000;
        end
      endcase
    end
    if (q.busy) begin
      // One quarter bit per QTR_CYC cycles; the default SCL_QTR_CYC keeps the clock at 400 kHz or less.
      d.div = (q.div == QTR_LAST) ? 16'h0000 : q.div + 16'h0001;
      if (q.div == QTR_LAST) begin
        d.qtr = q.qtr + 2'd1;
        unique case (kind)
          K_START: unique case (q.qtr)
            2'd0: d.sda_low = 1'b0;
            2'd1: d.scl_low = 1'b0;
            2'd2: d.sda_low = 1'b1;
            2'd3: begin
              d.scl_low = 1'b1;
              d.step = q.step + 3'd1;
            end
          endcase
          K_TX, K_RX: unique case (q.qtr)
            2'd0: if (q.bitn == 4'h8 || kind == K_RX) begin
              d.sda_low = 1'b0; // Acknowledge slot released, or NACK.
            end else begin
              d.sda_low = ~tx_byte[3'(4'h7 - q.bitn)];
            end
            2'd1: d.scl_low = 1'b0;
            2'd2: if (kind == K_TX && q.bitn == 4'h8) begin
              d.nack = q.s2;
            end else if (kind == K_RX && q.bitn != 4'h8) begin
              d.rdata = {q.rdata[6:0], q.s2};
            end
            2'd3: begin
              d.scl_low = 1'b1;
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == 4'h8) begin
                d.bitn = 4'h0;
                d.step = q.nack ? stop_step : q.step + 3'd1;
              end
            end
          endcase
          K_STOP: unique case (q.qtr)
            2'd0: d.sda_low = 1'b1;
            2'd1: d.scl_low = 1'b0;
            2'd2: d.sda_low = 1'b0;
            2'd3: d.busy = 1'b0;
          endcase
        endcase
      end
    end
  end

  // ========================================================================
  // State register; reset holds the receiver in power-down so that its
  // release later gives the serial logic its power-up reset.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= `HC_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ========================================================================
  // Pins. In legacy mode the data and clock lines carry strap levels.
  assign rdata_o = q.rdq;
  assign busy_o = q.busy;
  assign pins.mode_strap = q.ctrl[`HC_MODE];
  assign pins.power_down_n = q.ctrl[`HC_PDN];
  assign pins.output_disable_n = q.ctrl[`HC_ODN];
  assign pins.serial_sel = q.ctrl[`HC_MODE] & q.ctrl[`HC_SEL];
  assign pins.host_scl_o = 1'b0;
  assign pins.host_sda_o = 1'b0;
  assign pins.host_scl_oen = q.ctrl[`HC_MODE] ? q.ctrl[`HC_OCKINV] : ~q.scl_low;
  assign pins.host_sda_oen = q.ctrl[`HC_MODE] ? q.ctrl[`HC_ST] : ~q.sda_low;
endmodule

// ==== bench/rx_cfg_properties.sv ====
// Protocol checker for the pins that join the host end and the receiver end.
module rx_cfg_properties #(
  parameter int QTR_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_strap,
  input wire logic power_down_n,
  input wire logic serial_sel,
  input wire logic host_scl_o,
  input wire logic host_scl_oen,
  input wire logic host_sda_oen,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oen,
  input wire logic scl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Run length of the serial clock level; it saturates so idle time never wraps.
  logic [15:0] run_q;
  logic scl_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 16'h0000;
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl;
      run_q <= (scl != scl_q) ? 16'h0000 : run_q + {15'h0000, ~&run_q};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // The sync stages give the receiver three cycles to let go of the data line.
  a_legacy_quiet: assert property (mode_strap [*4] |-> dev_sda_oen)
    else $error("receiver drives data line in legacy mode");
  a_pd_quiet: assert property (!power_down_n [*4] |-> dev_sda_oen)
    else $error("receiver drives data line while powered down");
  a_sel_low: assert property (!mode_strap |-> !serial_sel)
    else $error("serial select high in programmable mode");
  a_dev_open_drain: assert property (!dev_sda_oen |-> !dev_sda_o)
    else $error("receiver drives a high level on the data line");
  a_host_open_drain: assert property (!host_scl_oen |-> !host_scl_o)
    else $error("host drives a high level on the serial clock");
  // Both half periods of the serial clock last at least a quarter bit.
  a_scl_high_min: assert property ($fell(scl) && !mode_strap |-> int'(run_q) >= QTR_CYC)
    else $error("serial clock high phase too short");
  a_scl_low_min: assert property ($rose(scl) && !mode_strap |-> int'(run_q) >= QTR_CYC)
    else $error("serial clock low phase too short");
  // The receiver may only move the data line while the clock is low.
  a_dev_sda_stable: assert property (
    $changed(dev_sda_oen) && power_down_n && !mode_strap |-> !scl)
    else $error("receiver changed data line with clock high");
  // Both ends may pull low together on an open-drain line, so that is legal.
  // When a receiver bit is clocked in, however, the host must have let go.
  a_no_contention: assert property ($rose(scl) && !dev_sda_oen |-> host_sda_oen)
    else $error("host pulls data line while receiver bit is sampled");
endmodule

// ==== bench/test_receiver_mode_and_config_control.sv ====
// Self-checking testbench for the host end and receiver end joined by their link.
module test_receiver_mode_and_config_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Short quarter bit keeps each serial transfer near 930 cycles for a write and 1250 for a read.
  localparam int QTR = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic busy;
  logic [23:0] pix = 24'h000000;
  logic de = 1'b0;
  logic [23:0] pix_o;
  logic de_o, voen, pden, prog, stag_n, drv, clock_de_drive_strength, ockinv;
  logic [3:0] eq, eqs;
  logic [1:0] pll_bandwidth_sel;
  logic [2:0] mhz;
  logic [2:0] bw [4] = '{3'h4, 3'h3, 3'h6, 3'h5};
  logic [7:0] mon_sh = 8'h00;
  logic scl_p = 1'b1;
  logic sda_p = 1'b1;
  int mon_n = 8;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 clk_i = ~clk_i;

  rx_cfg_if link();
  rx_cfg_host #(.QTR_CYC(QTR)) rx_cfg_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy),
    .pins(link));
  rx_cfg_dev rx_cfg_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins(link),
    .pixel_i(pix), .de_i(de), .hsync_i(1'b0), .vsync_i(1'b0), .zone_i(1'b1), .pixel_o(pix_o),
    .de_o(de_o), .hsync_o(), .vsync_o(), .video_oen_o(voen), .pulldown_en_o(pden),
    .prog_mode_o(prog), .equalizer_setting_o(eq), .eq_strength_o(eqs),
    .pll_bandwidth_sel_o(pll_bandwidth_sel), .pll_bw_mhz_o(mhz), .staggered_output_n_o(stag_n),
    .data_drive_strength_o(drv), .clock_de_drive_strength_o(clock_de_drive_strength),
    .out_clock_invert_o(ockinv));
  rx_cfg_properties #(.QTR_CYC(QTR)) rx_cfg_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .mode_strap(link.mode_strap), .power_down_n(link.power_down_n),
    .serial_sel(link.serial_sel), .host_scl_o(link.host_scl_o),
    .host_scl_oen(link.host_scl_oen), .host_sda_oen(link.host_sda_oen),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oen(link.dev_sda_oen), .scl(link.scl));

  // ==========================================================================
  // Wire monitor: keeps the first eight bits after each start, MSB first.
  always @(posedge clk_i) begin
    if (link.scl && scl_p && sda_p && !link.sda) begin
      mon_n = 0;
    end else if (link.scl && !scl_p && mon_n < 8) begin
      mon_sh = {mon_sh[6:0], link.sda};
      mon_n++;
    end
    scl_p = link.scl;
    sda_p = link.sda;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Shared bus cycles and comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // Read data stand from the cycle after the strobe until the next read strobe.
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) mismatches++;
  endtask
  // Pin changes pass two sync stages, so wait well past three cycles.
  task automatic ctrl(input logic [7:0] v);
    wr_reg(2'h0, v);
    repeat (6) @(posedge clk_i);
    #1;
  endtask
  task automatic sw(input logic [3:0] r, input logic [7:0] v);
    wr_reg(2'h2, v);
    wr_reg(2'h1, {4'h0, r});
    wait_idle();
  endtask
  task automatic sr(input logic [3:0] r, output logic [7:0] d);
    wr_reg(2'h1, {4'h1, r});
    wait_idle();
    rd_reg(2'h2, d);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_legacy();
    repeat (6) @(posedge clk_i);
    #1 chk({prog, voen, pden}, 3'h3);
    chk({clock_de_drive_strength, stag_n, drv, ockinv, eq}, 8'h6d);
    ctrl(8'h2d);
    chk({stag_n, drv, ockinv}, 3'h5);
    $display("t_legacy done");
  endtask
  task automatic t_prog();
    ctrl(8'h06);
    chk({prog, voen, pden}, 3'h4);
    @(posedge clk_i);
    pix <= 24'ha5c3e1;
    de <= 1'b1;
    @(posedge clk_i);
    #1 chk({de_o, pix_o}, 25'h1a5c3e1);
    ctrl(8'h02);
    chk({voen, pden}, 2'h3);
    ctrl(8'h06);
    chk({voen, pden}, 2'h0);
    $display("t_prog done");
  endtask
  // Every bandwidth code, with the zone input held high in its read-back.
  task automatic t_regs();
    logic [7:0] d;
    sw(4'h9, 8'h03);
    chk(mon_sh, 8'hec);
    sr(4'h9, d);
    chk({mon_sh, d, eqs}, 20'hed03c);
    for (int i = 0; i < 4; i++) begin
      sw(4'hb, 8'(i));
      sr(4'hb, d);
      chk({d, pll_bandwidth_sel, mhz}, {4'h0, 2'h2, 2'(i), 2'(i), bw[i]});
    end
    // Output control register: staggered and data drive bits cleared, the others set.
    sw(4'ha, 8'h18);
    chk({stag_n, drv, clock_de_drive_strength, ockinv}, 4'h3);
    $display("t_regs done");
  endtask
  // Power-down clears settings and refuses transfers; release brings back access.
  task automatic t_pd();
    logic [7:0] d;
    ctrl(8'h04);
    chk({voen, eq, pll_bandwidth_sel, pix_o}, {1'b1, 4'hd, 2'h0, 24'h000000});
    sw(4'h9, 8'h01);
    rd_reg(2'h3, d);
    chk({d[1], eq}, 5'h1d);
    ctrl(8'h06);
    sw(4'h9, 8'h05);
    sr(4'h9, d);
    chk(d, 8'h05);
    // Legacy straps keep both lines high, so the toggle makes no short clock phase.
    ctrl(8'h37);
    ctrl(8'h06);
    chk(eq, 4'hd);
    $display("t_pd done");
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_legacy();
    t_prog();
    t_regs();
    t_pd();
    end_of_test();
  end
endmodule
